// ---- common/pssc_pkg.sv ----
// pssc_pkg: shared constants and types for the pump start/stop supervisor.
// assumes a single 100 MHz clock domain and synchronous active-low reset.
`default_nettype none
package pssc_pkg;
  // ****************************************
  // source selection
  // ****************************************
  typedef enum logic [1:0] {
    PSSC_SRC_PANEL  = 2'h0,
    PSSC_SRC_WIRED  = 2'h1,
    PSSC_SRC_FBUS   = 2'h2,
    PSSC_SRC_FBWIRE = 2'h3
  } pssc_src_t;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned PSSC_CLK_HZ = 100_000_000;
  localparam int unsigned PSSC_FB_TIMEOUT_S = 10;
  localparam longint unsigned PSSC_FB_TIMEOUT_CYC = longint'(PSSC_FB_TIMEOUT_S) * longint'(PSSC_CLK_HZ);
  localparam int unsigned PSSC_DEB_MS = 10;
  localparam int unsigned PSSC_DEB_CYC = PSSC_DEB_MS * (PSSC_CLK_HZ / 1000);
  localparam int unsigned PSSC_NUM_IN = 7;
  // input bit positions in the packed remote input vector
  localparam int unsigned PSSC_IN_START = 0;
  localparam int unsigned PSSC_IN_STOP = 1;
  localparam int unsigned PSSC_IN_ENABLE = 2;
  localparam int unsigned PSSC_IN_DIR = 3;
  localparam int unsigned PSSC_IN_FULL = 4;
  localparam int unsigned PSSC_IN_EMPTY = 5;
  localparam int unsigned PSSC_IN_LEAK = 6;

  typedef enum logic [2:0] {
    PSSC_ST_IDLE = 3'h1,
    PSSC_ST_RUN  = 3'h2,
    PSSC_ST_FAIL = 3'h4
  } pssc_state_t;
endpackage : pssc_pkg
`default_nettype wire

// ---- common/pssc_in_if.sv ----
// pssc_in_if: carries clean remote input levels from the conditioner to the core.
// assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface pssc_in_if #(parameter int unsigned N = 7);
  logic [N-1:0] clean;
  modport src (output clean);
  modport dst (input clean);
endinterface : pssc_in_if
`default_nettype wire

// ---- rtl/pssc_debounce.sv ----
// pssc_debounce: two-flop synchroniser and debounce for each remote input.
// assumes raw inputs are already active high (closed contact = 1).
`timescale 1ns/1ns
`default_nettype none
module pssc_debounce #(
  parameter int unsigned N = 7,
  parameter int unsigned DEB_CYC = 1_000_000
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [N-1:0] raw,
  pssc_in_if.src outs
);
  localparam int unsigned CW = $clog2(DEB_CYC + 1);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] clean;
    logic [N-1:0][CW-1:0] cnt;
  } pssc_deb_t;
  pssc_deb_t st_q, st_d;

  // ****************************************
  // per-input filter
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    for (int i = 0; i < int'(N); i++) begin
      // level must hold for the whole window before it is believed
      if (st_q.s2[i] == st_q.clean[i]) begin
        st_d.cnt[i] = '0;
      end else if (st_q.cnt[i] == CW'(DEB_CYC - 1)) begin
        st_d.cnt[i] = '0;
        st_d.clean[i] = st_q.s2[i];
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign outs.clean = st_q.clean;

  // ****************************************
  // checks
  // ****************************************
  sync_delay_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && $past(ce) && st_q.clean != $past(st_q.clean) |-> st_q.clean == $past(st_q.s2))
    else $error("clean level did not come from the second sync stage");
endmodule : pssc_debounce
`default_nettype wire

// ---- rtl/pssc_core.sv ----
// pssc_core: pump run/stop, direction and alarm supervisor.
// assumes remote contacts arrive unsynchronised and active low (closed = 0),
// and that fieldbus run and message-valid strobes are synchronous to ref_clk.
// How it works
// - only the configured source commands run/stop; panel stop acts from any source
// - fieldbus run bit; 10 s silence stops
// - failsafe configured: timeout enters failsafe conditions
// - fieldbus-plus-wired: external stop forces off
// - panel stop beats everything
// - maintained: run only while start held
// - momentary: pulse latches run until stop
// - inhibit blocks remote start
// - remote stop closed permits; open stops
// - remote enable open disables wired start, stop and direction in wired source; alarms still act
// - direction open cw, closed ccw
// - direction changes only while stopped or in failsafe
// - any alarm input drives common alarm
`timescale 1ns/1ns
`default_nettype none
module pssc_core
  import pssc_pkg::*;
#(
  parameter longint unsigned FB_TIMEOUT_CYC = pssc_pkg::PSSC_FB_TIMEOUT_CYC,
  parameter int unsigned DEB_CYC = pssc_pkg::PSSC_DEB_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire pssc_pkg::pssc_src_t src_sel,
  input wire logic maintained_mode,
  input wire logic failsafe_en,
  input wire logic failsafe_run,
  input wire logic failsafe_ccw,
  input wire logic panel_start,
  input wire logic panel_stop,
  input wire logic panel_ccw,
  input wire logic fb_run,
  input wire logic fb_ccw,
  input wire logic fb_msg_valid,
  input wire logic inhibit,
  input wire logic start_n,
  input wire logic stop_n,
  input wire logic enable_n,
  input wire logic dir_n,
  input wire logic dest_full_n,
  input wire logic src_empty_n,
  input wire logic leak_n,
  output logic motor_run,
  output logic motor_ccw,
  output logic alarm_out,
  output logic alarm_display,
  output logic fb_detected,
  output logic failsafe_active
);
  import pssc_pkg::*;
  localparam int unsigned TW = $clog2(FB_TIMEOUT_CYC + 1);

  // ****************************************
  // input conditioning
  // ****************************************
  pssc_in_if #(.N(PSSC_NUM_IN)) cond ();
  logic [PSSC_NUM_IN-1:0] raw;
  // open contact reads high, so inversion makes open = inactive
  assign raw = ~{leak_n, src_empty_n, dest_full_n, dir_n, enable_n, stop_n, start_n};

  pssc_debounce #(.N(PSSC_NUM_IN), .DEB_CYC(DEB_CYC)) u_deb (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .raw(raw),
    .outs(cond.src)
  );

  logic r_start, r_stop_ok, r_en, r_dir, r_full, r_empty, r_leak;
  assign r_start = cond.clean[PSSC_IN_START];
  assign r_stop_ok = cond.clean[PSSC_IN_STOP];
  assign r_en = cond.clean[PSSC_IN_ENABLE];
  assign r_dir = cond.clean[PSSC_IN_DIR];
  assign r_full = cond.clean[PSSC_IN_FULL];
  assign r_empty = cond.clean[PSSC_IN_EMPTY];
  assign r_leak = cond.clean[PSSC_IN_LEAK];

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pssc_state_t st;
    logic [TW-1:0] tmo;
    logic fb_ok;
    logic ccw;
    logic alarm;
    logic run;
    logic fs;
  } pssc_core_t;
  pssc_core_t s_q, s_d;

  logic wired_ok, want_run, stop_cond, start_req, next_ccw;
  always_comb begin
    s_d = s_q;
    // wired interlocks: enable and stop permissive both closed
    wired_ok = r_en && r_stop_ok;
    want_run = 1'b0;
    stop_cond = 1'b0;
    start_req = 1'b0;
    next_ccw = s_q.ccw;

    // fieldbus message watchdog
    if (fb_msg_valid) begin
      s_d.tmo = '0;
      s_d.fb_ok = 1'b1;
    end else if (s_q.tmo == TW'(FB_TIMEOUT_CYC - 1)) begin
      s_d.fb_ok = 1'b0;
    end else begin
      s_d.tmo = s_q.tmo + TW'(1);
    end

    unique case (src_sel)
      PSSC_SRC_PANEL: begin
        start_req = panel_start;
        next_ccw = panel_ccw;
      end
      PSSC_SRC_WIRED: begin
        start_req = wired_ok && r_start && !inhibit;
        stop_cond = !wired_ok || inhibit;
        if (maintained_mode && !r_start) begin
          stop_cond = 1'b1;
        end
        next_ccw = wired_ok ? r_dir : s_q.ccw;
      end
      PSSC_SRC_FBUS, PSSC_SRC_FBWIRE: begin
        want_run = fb_run && s_q.fb_ok;
        next_ccw = fb_ccw;
        if (src_sel == PSSC_SRC_FBWIRE && !r_stop_ok) begin
          want_run = 1'b0;
        end
      end
    endcase

    unique case (s_q.st)
      PSSC_ST_IDLE: begin
        s_d.ccw = next_ccw;
        if (src_sel == PSSC_SRC_FBUS || src_sel == PSSC_SRC_FBWIRE) begin
          if (want_run) begin
            s_d.st = PSSC_ST_RUN;
          end
        end else if (start_req && !stop_cond) begin
          s_d.st = PSSC_ST_RUN;
        end
      end
      PSSC_ST_RUN: begin
        if (src_sel == PSSC_SRC_FBUS || src_sel == PSSC_SRC_FBWIRE) begin
          if (!s_q.fb_ok && failsafe_en && r_stop_ok | (src_sel == PSSC_SRC_FBUS)) begin
            s_d.st = PSSC_ST_FAIL;
          end else if (!want_run) begin
            s_d.st = PSSC_ST_IDLE;
          end
        end else if (stop_cond) begin
          s_d.st = PSSC_ST_IDLE;
        end
      end
      PSSC_ST_FAIL: begin
        // leave failsafe on fresh traffic, failsafe withdrawn, a change to panel or wired source or an external stop
        if (s_q.fb_ok || !failsafe_en || src_sel == PSSC_SRC_PANEL || src_sel == PSSC_SRC_WIRED) begin
          s_d.st = PSSC_ST_IDLE;
        end else if (src_sel == PSSC_SRC_FBWIRE && !r_stop_ok) begin
          s_d.st = PSSC_ST_IDLE;
        end else begin
          s_d.ccw = failsafe_ccw;
        end
      end
      default: s_d.st = PSSC_ST_IDLE;
    endcase

    // failsafe with no fieldbus while idle also takes over
    if (s_q.st == PSSC_ST_IDLE && !s_q.fb_ok && failsafe_en
        && (src_sel == PSSC_SRC_FBUS || (src_sel == PSSC_SRC_FBWIRE && r_stop_ok))) begin
      s_d.st = PSSC_ST_FAIL;
    end

    if (panel_stop) begin
      s_d.st = PSSC_ST_IDLE;
    end

    s_d.alarm = r_full || r_empty || r_leak;
    // run and failsafe flags registered so the outputs come straight from flops
    s_d.run = (s_d.st == PSSC_ST_RUN) || (s_d.st == PSSC_ST_FAIL && failsafe_run);
    s_d.fs = s_d.st == PSSC_ST_FAIL;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_q.st <= PSSC_ST_IDLE;
      s_q.tmo <= '0;
      s_q.fb_ok <= 1'b0;
      s_q.ccw <= 1'b0;
      s_q.alarm <= 1'b0;
      s_q.run <= 1'b0;
      s_q.fs <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign motor_run = s_q.run;
  assign motor_ccw = s_q.ccw;
  assign alarm_out = s_q.alarm;
  assign alarm_display = s_q.alarm;
  assign fb_detected = s_q.fb_ok;
  assign failsafe_active = s_q.fs;

  // ****************************************
  // checks
  // ****************************************
  panel_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && panel_stop |=> s_q.st == PSSC_ST_IDLE)
    else $error("panel stop did not stop the motor");
  fb_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && src_sel == PSSC_SRC_FBWIRE && !r_stop_ok && s_q.st != PSSC_ST_IDLE |=> s_q.st == PSSC_ST_IDLE)
    else $error("external stop did not override fieldbus");
  dir_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st == PSSC_ST_RUN && $past(s_q.st) == PSSC_ST_RUN |-> $stable(s_q.ccw))
    else $error("direction changed while running");
  inhibit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && src_sel == PSSC_SRC_WIRED && inhibit && s_q.st == PSSC_ST_IDLE |=> s_q.st == PSSC_ST_IDLE)
    else $error("start accepted while inhibited");
  enable_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && src_sel == PSSC_SRC_WIRED && !r_en |=> s_q.st != PSSC_ST_RUN)
    else $error("wired run with remote enable open");
  alarm_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (r_full || r_leak || r_empty) |=> alarm_out && alarm_display)
    else $error("alarm input not reflected");
  maint_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && src_sel == PSSC_SRC_WIRED && maintained_mode && !r_start |=> s_q.st == PSSC_ST_IDLE)
    else $error("maintained run without start held");
  fb_tmo_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && src_sel == PSSC_SRC_FBUS && !s_q.fb_ok && !failsafe_en |=> s_q.st == PSSC_ST_IDLE)
    else $error("fieldbus timeout did not stop motor");
  dir_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && src_sel == PSSC_SRC_WIRED && s_q.st == PSSC_ST_IDLE && r_en && r_stop_ok |=> motor_ccw == $past(r_dir))
    else $error("wired direction not taken while stopped");
  ce_freeze_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ce |=> $stable(s_q))
    else $error("state moved while clock enable low");
endmodule : pssc_core
`default_nettype wire

// ---- verification/pssc_contacts.sv ----
// pssc_contacts: plant contacts wired to the pump's remote connector.
// assumes the bench says which contacts are closed; an open pin is pulled high.
`timescale 1ns/1ns
`default_nettype none
module pssc_contacts (
  input wire logic [6:0] closed,
  output logic start_n,
  output logic stop_n,
  output logic enable_n,
  output logic dir_n,
  output logic dest_full_n,
  output logic src_empty_n,
  output logic leak_n
);
  import pssc_pkg::*;
  // a closed contact grounds the pin, an open one floats to the pull-up
  assign start_n = ~closed[PSSC_IN_START];
  assign stop_n = ~closed[PSSC_IN_STOP];
  assign enable_n = ~closed[PSSC_IN_ENABLE];
  assign dir_n = ~closed[PSSC_IN_DIR];
  assign dest_full_n = ~closed[PSSC_IN_FULL];
  assign src_empty_n = ~closed[PSSC_IN_EMPTY];
  assign leak_n = ~closed[PSSC_IN_LEAK];
endmodule : pssc_contacts
`default_nettype wire

// ---- verification/test_pump_start_stop_control.sv ----
// test_pump_start_stop_control: self-checking bench for the start/stop supervisor.
// assumes short timeout and debounce parameters; contacts settle within S cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %b seen %b", nm, e, g); end end
module test_pump_start_stop_control;
  import pssc_pkg::*;
  localparam int FBT = 200;
  localparam int DEB = 4;
  localparam int S = 14;
  logic ref_clk, resetn, mm, fs_en, fs_run, p_start, p_stop, fb_run, fb_vld, inhibit;
  logic ce, p_ccw, fb_ccw, fs_ccw;
  pssc_src_t src;
  logic [6:0] cl;
  logic start_n, stop_n, enable_n, dir_n, full_n, empty_n, leak_n;
  logic motor_run, motor_ccw, alarm_out, alarm_display, fb_detected, failsafe_active;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'hb3e5;
  pssc_contacts pssc_contacts_i (.closed(cl), .start_n(start_n), .stop_n(stop_n), .enable_n(enable_n),
    .dir_n(dir_n), .dest_full_n(full_n), .src_empty_n(empty_n), .leak_n(leak_n));
  pssc_core #(.FB_TIMEOUT_CYC(FBT), .DEB_CYC(DEB)) pssc_core_i (.ref_clk(ref_clk), .resetn(resetn),
    .ce(ce), .src_sel(src), .maintained_mode(mm), .failsafe_en(fs_en), .failsafe_run(fs_run),
    .failsafe_ccw(fs_ccw), .panel_start(p_start), .panel_stop(p_stop), .panel_ccw(p_ccw),
    .fb_run(fb_run), .fb_ccw(fb_ccw), .fb_msg_valid(fb_vld), .inhibit(inhibit), .start_n(start_n),
    .stop_n(stop_n), .enable_n(enable_n), .dir_n(dir_n), .dest_full_n(full_n),
    .src_empty_n(empty_n), .leak_n(leak_n), .motor_run(motor_run), .motor_ccw(motor_ccw),
    .alarm_out(alarm_out), .alarm_display(alarm_display), .fb_detected(fb_detected),
    .failsafe_active(failsafe_active));
  task automatic print_verdict;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step
  // one message lasts exactly one cycle, as the strobe is a pulse
  task automatic fbmsg(input logic r);
    @(posedge ref_clk);
    fb_run <= r;
    fb_vld <= 1'b1;
    @(posedge ref_clk);
    fb_vld <= 1'b0;
  endtask : fbmsg
  function automatic int rnd(input int span);
    return $unsigned($random(seed)) % span;
  endfunction : rnd
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    resetn = 1'b0; src = PSSC_SRC_PANEL; mm = 1'b1; fs_en = 1'b0; fs_run = 1'b0; cl = 7'h00;
    p_start = 1'b0; p_stop = 1'b0; fb_run = 1'b0; fb_vld = 1'b0; inhibit = 1'b1;
    ce = 1'b1; p_ccw = 1'b0; fb_ccw = 1'b0; fs_ccw = 1'b0;
    step(2);
    resetn <= 1'b1;
    step(1);
    `CHK("run_after_reset", 1'b0, motor_run)
    src <= PSSC_SRC_WIRED; cl <= 7'h07;
    step(S);
    `CHK("run_inhibited", 1'b0, motor_run)
    inhibit <= 1'b0;
    step(S);
    `CHK("run_maintained", 1'b1, motor_run)
    cl <= 7'h06;
    step(S);
    `CHK("run_released", 1'b0, motor_run)
    cl <= 7'h03;
    step(S);
    `CHK("run_disabled", 1'b0, motor_run)
    // a start blip shorter than the debounce window must not latch a run
    mm <= 1'b0; cl <= 7'h06;
    step(S);
    cl <= 7'h07;
    step(1 + rnd(DEB - 2));
    cl <= 7'h06;
    step(S);
    `CHK("start_glitch", 1'b0, motor_run)
    cl <= 7'h07;
    step(DEB + 3 + rnd(5));
    cl <= 7'h06;
    step(S);
    `CHK("run_latched", 1'b1, motor_run)
    cl <= 7'h04;
    step(S);
    `CHK("run_stop_open", 1'b0, motor_run)
    cl <= 7'h05;
    step(S);
    `CHK("start_stop_open", 1'b0, motor_run)
    cl <= 7'h0E;
    step(S);
    `CHK("ccw_idle", 1'b1, motor_ccw)
    mm <= 1'b1; cl <= 7'h0F;
    step(S);
    cl <= 7'h07;
    step(S + rnd(8));
    `CHK("ccw_running", 1'b1, motor_ccw)
    cl <= 7'h06;
    step(S);
    `CHK("cw_stopped", 1'b0, motor_ccw)
    for (int k = PSSC_IN_FULL; k <= PSSC_IN_LEAK; k++) begin
      cl <= 7'h06 | (7'h01 << k);
      step(S);
      `CHK("alarm_out", 1'b1, alarm_out)
      `CHK("alarm_display", 1'b1, alarm_display)
      cl <= 7'h06;
      step(S);
      `CHK("alarm_clear", 1'b0, alarm_out)
    end
    src <= PSSC_SRC_PANEL; cl <= 7'h07; p_ccw <= 1'(rnd(2));
    step(S);
    `CHK("panel_ignores_wired", 1'b0, motor_run)
    p_start <= 1'b1;
    step(3);
    `CHK("panel_run", 1'b1, motor_run)
    `CHK("panel_ccw", p_ccw, motor_ccw)
    ce <= 1'b0; p_stop <= 1'b1;
    step(3);
    `CHK("ce_freeze", 1'b1, motor_run)
    ce <= 1'b1;
    step(3);
    `CHK("panel_stop_wins", 1'b0, motor_run)
    p_start <= 1'b0; p_stop <= 1'b0; src <= PSSC_SRC_FBUS; fb_ccw <= 1'(rnd(2));
    fbmsg(1'b1);
    step(3);
    `CHK("fb_detected", 1'b1, fb_detected)
    `CHK("fb_run", 1'b1, motor_run)
    `CHK("fb_ccw", fb_ccw, motor_ccw)
    step(FBT + 10);
    `CHK("fb_timeout", 1'b0, motor_run)
    fs_en <= 1'b1; fs_run <= 1'b1; fs_ccw <= 1'b1;
    step(3);
    `CHK("failsafe_active", 1'b1, failsafe_active)
    `CHK("failsafe_run", 1'b1, motor_run)
    `CHK("failsafe_ccw", 1'b1, motor_ccw)
    fbmsg(1'b0);
    step(3);
    `CHK("failsafe_left", 1'b0, failsafe_active)
    fs_en <= 1'b0; src <= PSSC_SRC_FBWIRE; fb_ccw <= ~fb_ccw;
    fbmsg(1'b1);
    step(S);
    `CHK("fbwire_run", 1'b1, motor_run)
    `CHK("fbwire_ccw", fb_ccw, motor_ccw)
    p_stop <= 1'b1;
    step(3);
    `CHK("fbwire_panel_stop", 1'b0, motor_run)
    p_stop <= 1'b0;
    step(3);
    `CHK("fbwire_resume", 1'b1, motor_run)
    cl <= 7'h05;
    step(S);
    `CHK("fbwire_estop", 1'b0, motor_run)
    print_verdict();
  end
  initial begin
    step(6000);
    n_mismatch++;
    print_verdict();
  end
endmodule : test_pump_start_stop_control
`default_nettype wire
